// ==== logic/uart_page_pkg.sv ====
// Constants, types and page decoding for one serial channel's paged register map
//
// Overview of operation
// - Each channel has own set; three address lines
// - Page 0: interrupt enable read/write at 1h
// - Page 0 at 0h: write transmit, read receive
// - Pages 0-1 2h: write fifo control, read status
// - Page 1 at 0h/1h: divisor low/high bytes
// - Pages 0-1: 5h line, 6h modem status
// - Pages 0-1: 7h scratch pad, no side effect
// - Line control at 3h in every page
// - Modem control at 4h in pages 0-2
// - Page 2 at 1h: write-only global mask
// - Page 2: 2h global status, 0h unmapped
// - Page 2: 5h/6h read fifo fill counts
// - Page 2: 7h reads flow control status
// - Line control BFh: page select at 0h
// - Page 3: 1h auto toggle, 2h enhanced
// - Page 3: 4h-7h resume and pause characters
// - Page 4: 1h additional feature, 2h resend count
// - Page 4: 4h/5h transmit and receive triggers
// - Page 4: 6h/7h upper and lower thresholds

package uart_page_pkg;

  // Offsets; each slot except 3h is shared by different registers across the pages
  localparam logic [2:0] OFS_DATA    = 3'h0;
  localparam logic [2:0] OFS_ENABLE  = 3'h1;
  localparam logic [2:0] OFS_FIFO    = 3'h2;
  localparam logic [2:0] OFS_LINE    = 3'h3;
  localparam logic [2:0] OFS_MODEM   = 3'h4;
  localparam logic [2:0] OFS_LSTAT   = 3'h5;
  localparam logic [2:0] OFS_MSTAT   = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  localparam logic [7:0] LINE_PAGE_KEY    = 8'hbf;
  localparam int         LINE_DIV_BIT     = 7;
  localparam int         MODEM_PAGE2_BIT  = 6;
  localparam int         SELECT_PAGE4_BIT = 0;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;
  localparam logic [7:0] RESET_BYTE       = 8'h00;

  typedef enum logic [4:0] {
    PAGE0 = 5'b00001,
    PAGE1 = 5'b00010,
    PAGE2 = 5'b00100,
    PAGE3 = 5'b01000,
    PAGE4 = 5'b10000
  } page_t;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] int_enable;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] scratch_pad;
    logic [7:0] page_select;
    logic [7:0] auto_toggle_control;
    logic [7:0] enhanced_feature;
    logic [7:0] resume_char_1;
    logic [7:0] resume_char_2;
    logic [7:0] pause_char_1;
    logic [7:0] pause_char_2;
    logic [7:0] additional_feature;
    logic [7:0] pause_resend_count;
    logic [7:0] tx_trigger_level;
    logic [7:0] rx_trigger_level;
    logic [7:0] flow_upper_threshold;
    logic [7:0] flow_lower_threshold;
  } cfg_t;

  typedef struct packed {
    logic [7:0] rx_buffer;
    logic [7:0] int_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] global_int_status;
    logic [7:0] tx_fifo_count;
    logic [7:0] rx_fifo_count;
    logic [7:0] flow_status;
  } status_t;

  typedef struct packed {
    logic       tx_load;
    logic       fifo_load;
    logic       mask_load;
    logic       rx_pop;
    logic [7:0] data;
  } strobe_t;

  typedef struct packed {
    cfg_t       cfg;
    strobe_t    strb;
    logic [7:0] rdata;
  } state_t;

  localparam state_t STATE_RESET = '{
    cfg:   {19{RESET_BYTE}},
    strb:  '{tx_load: 1'b0, fifo_load: 1'b0, mask_load: 1'b0, rx_pop: 1'b0, data: RESET_BYTE},
    rdata: RESET_BYTE
  };

  // Key value wins over the divisor bit, since BFh has bit 7 set
  function automatic page_t page_of(input logic [7:0] line, input logic [7:0] modem,
                                    input logic [7:0] sel);
    page_t p;
    if (line == LINE_PAGE_KEY)
      p = sel[SELECT_PAGE4_BIT] ? PAGE4 : PAGE3;
    else if (line[LINE_DIV_BIT])
      p = PAGE1;
    else
      p = modem[MODEM_PAGE2_BIT] ? PAGE2 : PAGE0;
    return p;
  endfunction

endpackage

// ==== logic/uart_page_regs.sv ====
// Paged register bank and access decoder for one serial channel
`timescale 1ns/1ps
`default_nettype none

module uart_page_regs (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Host register access
  input  wire uart_page_pkg::bus_req_t bus,
  output logic [7:0]                  rdata,
  // Channel state read back by the host
  input  wire uart_page_pkg::status_t status,
  // Stored settings and access pulses toward the channel
  output uart_page_pkg::cfg_t         cfg,
  output uart_page_pkg::strobe_t      strb,
  output uart_page_pkg::page_t        page
);

  uart_page_pkg::state_t st_r;
  uart_page_pkg::state_t st_nxt;
  uart_page_pkg::page_t  pg;
  logic                  wr_en;
  logic                  rd_en;
  logic [7:0]            rd_val;

  assign wr_en = bus.cs && bus.wr;
  assign rd_en = bus.cs && bus.rd;
  assign pg    = uart_page_pkg::page_of(st_r.cfg.line_control, st_r.cfg.modem_control,
                                        st_r.cfg.page_select);

  // Read mux; holes fall through to the constant
  always_comb begin
    rd_val = uart_page_pkg::UNMAPPED_READ;
    if (bus.addr == uart_page_pkg::OFS_LINE) begin
      rd_val = st_r.cfg.line_control;
    end else begin
      case (pg)
        uart_page_pkg::PAGE0, uart_page_pkg::PAGE1: begin
          if (bus.addr == uart_page_pkg::OFS_DATA)
            rd_val = (pg == uart_page_pkg::PAGE0) ? status.rx_buffer
                                                  : st_r.cfg.divisor_low;
          else if (bus.addr == uart_page_pkg::OFS_ENABLE)
            rd_val = (pg == uart_page_pkg::PAGE0) ? st_r.cfg.int_enable
                                                  : st_r.cfg.divisor_high;
          else if (bus.addr == uart_page_pkg::OFS_FIFO)
            rd_val = status.int_status;
          else if (bus.addr == uart_page_pkg::OFS_MODEM)
            rd_val = st_r.cfg.modem_control;
          else if (bus.addr == uart_page_pkg::OFS_LSTAT)
            rd_val = status.line_status;
          else if (bus.addr == uart_page_pkg::OFS_MSTAT)
            rd_val = status.modem_status;
          else if (bus.addr == uart_page_pkg::OFS_SCRATCH)
            rd_val = st_r.cfg.scratch_pad;
        end
        uart_page_pkg::PAGE2: begin
          // Offset 0h and the write-only mask both read as the constant
          if (bus.addr == uart_page_pkg::OFS_FIFO)
            rd_val = status.global_int_status;
          else if (bus.addr == uart_page_pkg::OFS_MODEM)
            rd_val = st_r.cfg.modem_control;
          else if (bus.addr == uart_page_pkg::OFS_LSTAT)
            rd_val = status.tx_fifo_count;
          else if (bus.addr == uart_page_pkg::OFS_MSTAT)
            rd_val = status.rx_fifo_count;
          else if (bus.addr == uart_page_pkg::OFS_SCRATCH)
            rd_val = status.flow_status;
        end
        uart_page_pkg::PAGE3: begin
          if (bus.addr == uart_page_pkg::OFS_DATA)
            rd_val = st_r.cfg.page_select;
          else if (bus.addr == uart_page_pkg::OFS_ENABLE)
            rd_val = st_r.cfg.auto_toggle_control;
          else if (bus.addr == uart_page_pkg::OFS_FIFO)
            rd_val = st_r.cfg.enhanced_feature;
          else if (bus.addr == uart_page_pkg::OFS_MODEM)
            rd_val = st_r.cfg.resume_char_1;
          else if (bus.addr == uart_page_pkg::OFS_LSTAT)
            rd_val = st_r.cfg.resume_char_2;
          else if (bus.addr == uart_page_pkg::OFS_MSTAT)
            rd_val = st_r.cfg.pause_char_1;
          else if (bus.addr == uart_page_pkg::OFS_SCRATCH)
            rd_val = st_r.cfg.pause_char_2;
        end
        uart_page_pkg::PAGE4: begin
          if (bus.addr == uart_page_pkg::OFS_DATA)
            rd_val = st_r.cfg.page_select;
          else if (bus.addr == uart_page_pkg::OFS_ENABLE)
            rd_val = st_r.cfg.additional_feature;
          else if (bus.addr == uart_page_pkg::OFS_FIFO)
            rd_val = st_r.cfg.pause_resend_count;
          else if (bus.addr == uart_page_pkg::OFS_MODEM)
            rd_val = st_r.cfg.tx_trigger_level;
          else if (bus.addr == uart_page_pkg::OFS_LSTAT)
            rd_val = st_r.cfg.rx_trigger_level;
          else if (bus.addr == uart_page_pkg::OFS_MSTAT)
            rd_val = st_r.cfg.flow_upper_threshold;
          else if (bus.addr == uart_page_pkg::OFS_SCRATCH)
            rd_val = st_r.cfg.flow_lower_threshold;
        end
        default: rd_val = uart_page_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Write decode; page is judged from the settings before this write lands
  always_comb begin
    st_nxt = st_r;
    st_nxt.strb.tx_load   = 1'b0;
    st_nxt.strb.fifo_load = 1'b0;
    st_nxt.strb.mask_load = 1'b0;
    st_nxt.strb.rx_pop    = 1'b0;
    if (rd_en) begin
      st_nxt.rdata = rd_val;
      // Only a receive read consumes a byte; status reads are side-effect free
      if (pg == uart_page_pkg::PAGE0 && bus.addr == uart_page_pkg::OFS_DATA)
        st_nxt.strb.rx_pop = 1'b1;
    end
    if (wr_en) begin
      st_nxt.strb.data = bus.wdata;
      if (bus.addr == uart_page_pkg::OFS_LINE) begin
        st_nxt.cfg.line_control = bus.wdata;
      end else begin
        case (pg)
          uart_page_pkg::PAGE0, uart_page_pkg::PAGE1: begin
            if (bus.addr == uart_page_pkg::OFS_DATA) begin
              if (pg == uart_page_pkg::PAGE0)
                st_nxt.strb.tx_load = 1'b1;
              else
                st_nxt.cfg.divisor_low = bus.wdata;
            end else if (bus.addr == uart_page_pkg::OFS_ENABLE) begin
              if (pg == uart_page_pkg::PAGE0)
                st_nxt.cfg.int_enable = bus.wdata;
              else
                st_nxt.cfg.divisor_high = bus.wdata;
            end else if (bus.addr == uart_page_pkg::OFS_FIFO) begin
              st_nxt.strb.fifo_load = 1'b1;
            end else if (bus.addr == uart_page_pkg::OFS_MODEM) begin
              st_nxt.cfg.modem_control = bus.wdata;
            end else if (bus.addr == uart_page_pkg::OFS_SCRATCH) begin
              st_nxt.cfg.scratch_pad = bus.wdata;
            end
          end
          uart_page_pkg::PAGE2: begin
            // Status offsets take no write; the page bit stays reachable at 4h
            if (bus.addr == uart_page_pkg::OFS_ENABLE)
              st_nxt.strb.mask_load = 1'b1;
            else if (bus.addr == uart_page_pkg::OFS_MODEM)
              st_nxt.cfg.modem_control = bus.wdata;
          end
          uart_page_pkg::PAGE3: begin
            if (bus.addr == uart_page_pkg::OFS_DATA)
              st_nxt.cfg.page_select = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_ENABLE)
              st_nxt.cfg.auto_toggle_control = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_FIFO)
              st_nxt.cfg.enhanced_feature = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_MODEM)
              st_nxt.cfg.resume_char_1 = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_LSTAT)
              st_nxt.cfg.resume_char_2 = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_MSTAT)
              st_nxt.cfg.pause_char_1 = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_SCRATCH)
              st_nxt.cfg.pause_char_2 = bus.wdata;
          end
          uart_page_pkg::PAGE4: begin
            if (bus.addr == uart_page_pkg::OFS_DATA)
              st_nxt.cfg.page_select = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_ENABLE)
              st_nxt.cfg.additional_feature = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_FIFO)
              st_nxt.cfg.pause_resend_count = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_MODEM)
              st_nxt.cfg.tx_trigger_level = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_LSTAT)
              st_nxt.cfg.rx_trigger_level = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_MSTAT)
              st_nxt.cfg.flow_upper_threshold = bus.wdata;
            else if (bus.addr == uart_page_pkg::OFS_SCRATCH)
              st_nxt.cfg.flow_lower_threshold = bus.wdata;
          end
          default: st_nxt.cfg = st_r.cfg;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      st_r <= uart_page_pkg::STATE_RESET;
    else
      st_r <= st_nxt;
  end

  assign rdata = st_r.rdata;
  assign cfg   = st_r.cfg;
  assign strb  = st_r.strb;
  assign page  = pg;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_addr_page_map: assert property (rd_en && bus.addr == uart_page_pkg::OFS_MODEM &&
    (pg == uart_page_pkg::PAGE3) |=> rdata == $past(st_r.cfg.resume_char_1))
    else $error("Address and page did not select the right register");
  a_enable_rw: assert property (wr_en && pg == uart_page_pkg::PAGE0 &&
    bus.addr == uart_page_pkg::OFS_ENABLE |=> cfg.int_enable == $past(bus.wdata))
    else $error("Interrupt enable write lost");
  a_tx_load: assert property (wr_en && pg == uart_page_pkg::PAGE0 &&
    bus.addr == uart_page_pkg::OFS_DATA |=> strb.tx_load && strb.data == $past(bus.wdata)
    ##1 strb.tx_load == $past(wr_en && pg == uart_page_pkg::PAGE0 &&
    bus.addr == uart_page_pkg::OFS_DATA))
    else $error("Transmit load pulse wrong");
  a_rx_read_pop: assert property (rd_en && pg == uart_page_pkg::PAGE0 &&
    bus.addr == uart_page_pkg::OFS_DATA |=> strb.rx_pop && rdata == $past(status.rx_buffer))
    else $error("Receive read wrong");
  a_fifo_ctl: assert property (wr_en && bus.addr == uart_page_pkg::OFS_FIFO &&
    pg inside {uart_page_pkg::PAGE0, uart_page_pkg::PAGE1} |=> strb.fifo_load)
    else $error("Fifo control pulse missing");
  a_divisor_low: assert property (wr_en && pg == uart_page_pkg::PAGE1 &&
    bus.addr == uart_page_pkg::OFS_DATA |=> cfg.divisor_low == $past(bus.wdata) && !strb.tx_load)
    else $error("Divisor low write wrong");
  a_line_status: assert property (rd_en && pg == uart_page_pkg::PAGE1 &&
    bus.addr == uart_page_pkg::OFS_LSTAT |=> rdata == $past(status.line_status))
    else $error("Line status read wrong");
  a_scratch_pad: assert property (wr_en && pg == uart_page_pkg::PAGE0 &&
    bus.addr == uart_page_pkg::OFS_SCRATCH |=> cfg.scratch_pad == $past(bus.wdata)
    && !strb.tx_load && !strb.fifo_load && !strb.mask_load)
    else $error("Scratch pad write wrong");
  a_line_any_page: assert property (wr_en && bus.addr == uart_page_pkg::OFS_LINE
    |=> cfg.line_control == $past(bus.wdata))
    else $error("Line control write lost");
  a_modem_pages: assert property (wr_en && bus.addr == uart_page_pkg::OFS_MODEM &&
    pg == uart_page_pkg::PAGE2 |=> cfg.modem_control == $past(bus.wdata))
    else $error("Modem control write lost in page 2");
  a_mask_write: assert property (wr_en && pg == uart_page_pkg::PAGE2 &&
    bus.addr == uart_page_pkg::OFS_ENABLE |=> strb.mask_load && cfg == $past(cfg))
    else $error("Global mask write wrong");
  a_page2_hole: assert property (rd_en && pg == uart_page_pkg::PAGE2 &&
    bus.addr == uart_page_pkg::OFS_DATA |=> rdata == uart_page_pkg::UNMAPPED_READ && !strb.rx_pop)
    else $error("Page 2 hole not constant");
  a_fill_count: assert property (rd_en && pg == uart_page_pkg::PAGE2 &&
    bus.addr == uart_page_pkg::OFS_MSTAT |=> rdata == $past(status.rx_fifo_count))
    else $error("Fill count read wrong");
  a_flow_status: assert property (rd_en && pg == uart_page_pkg::PAGE2 &&
    bus.addr == uart_page_pkg::OFS_SCRATCH |=> rdata == $past(status.flow_status))
    else $error("Flow status read wrong");
  a_page_select: assert property (wr_en && bus.addr == uart_page_pkg::OFS_DATA &&
    cfg.line_control == uart_page_pkg::LINE_PAGE_KEY |=> cfg.page_select == $past(bus.wdata)
    && page == ($past(bus.wdata[0]) ? uart_page_pkg::PAGE4 : uart_page_pkg::PAGE3))
    else $error("Page select wrong");
  a_enhanced: assert property (wr_en && pg == uart_page_pkg::PAGE3 &&
    bus.addr == uart_page_pkg::OFS_FIFO |=> cfg.enhanced_feature == $past(bus.wdata)
    && !strb.fifo_load)
    else $error("Enhanced feature write wrong");
  a_pause_char: assert property (wr_en && pg == uart_page_pkg::PAGE3 &&
    bus.addr == uart_page_pkg::OFS_SCRATCH |=> cfg.pause_char_2 == $past(bus.wdata))
    else $error("Pause character write wrong");
  a_resend_count: assert property (wr_en && pg == uart_page_pkg::PAGE4 &&
    bus.addr == uart_page_pkg::OFS_FIFO |=> cfg.pause_resend_count == $past(bus.wdata))
    else $error("Resend count write wrong");
  a_trigger_rx: assert property (wr_en && pg == uart_page_pkg::PAGE4 &&
    bus.addr == uart_page_pkg::OFS_LSTAT |=> cfg.rx_trigger_level == $past(bus.wdata))
    else $error("Receive trigger write wrong");
  a_threshold_lo: assert property (wr_en && pg == uart_page_pkg::PAGE4 &&
    bus.addr == uart_page_pkg::OFS_SCRATCH |=> cfg.flow_lower_threshold == $past(bus.wdata))
    else $error("Lower threshold write wrong");
  a_readonly_write: assert property (wr_en && bus.addr == uart_page_pkg::OFS_LSTAT &&
    pg inside {uart_page_pkg::PAGE0, uart_page_pkg::PAGE2} |=> $stable(cfg)
    && !strb.tx_load && !strb.fifo_load && !strb.mask_load)
    else $error("Read-only write changed state");

  c_page3_write: cover property (wr_en && pg == uart_page_pkg::PAGE3);
  c_page4_read:  cover property (rd_en && pg == uart_page_pkg::PAGE4);
  c_page2_read:  cover property (rd_en && pg == uart_page_pkg::PAGE2);
  c_tx_then_rx:  cover property (strb.tx_load ##[1:20] strb.rx_pop);

endmodule

`default_nettype wire

// ==== sim/host_model.sv ====
// Host processor model issuing single-byte register cycles on the channel bus
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // Clock
  input  wire logic                    sys_clk,
  // Register bus toward the channel
  output var  uart_page_pkg::bus_req_t bus,
  input  wire logic [7:0]              rdata
);
  initial begin
    bus = '0;
  end

  // Idle address and data lines show the inverse of the last cycle so stale values never look valid; cs, rd and wr go low
  task automatic release_bus();
    bus.cs    = 1'b0;
    bus.rd    = 1'b0;
    bus.wr    = 1'b0;
    bus.addr  = ~bus.addr;
    bus.wdata = ~bus.wdata;
  endtask

  // Request set at a falling edge, taken at the next rising edge, answer read after it
  task automatic access(input logic rd, input logic wr, input logic [2:0] addr,
                        input logic [7:0] wdata, output logic [7:0] data);
    @(negedge sys_clk);
    bus = '{cs: 1'b1, rd: rd, wr: wr, addr: addr, wdata: wdata};
    @(negedge sys_clk);
    data = rdata;
    release_bus();
  endtask

  task automatic wr_byte(input logic [2:0] addr, input logic [7:0] wdata);
    logic [7:0] unused;
    access(1'b0, 1'b1, addr, wdata, unused);
  endtask

  task automatic rd_byte(input logic [2:0] addr, output logic [7:0] data);
    access(1'b1, 1'b0, addr, 8'h00, data);
  endtask

  // Caller must restore line control afterwards to leave the extended pages
  task automatic enter_page(input logic sel);
    wr_byte(3'h3, uart_page_pkg::LINE_PAGE_KEY);
    wr_byte(3'h0, {7'h00, sel});
  endtask
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the paged register bank of one serial channel
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                    sys_clk = 1'b0;
  logic                    rst     = 1'b1;
  uart_page_pkg::bus_req_t bus;
  uart_page_pkg::status_t  status;
  uart_page_pkg::cfg_t     cfg;
  uart_page_pkg::strobe_t  strb;
  uart_page_pkg::page_t    page;
  logic [7:0]              rdata;
  int                      err_total = 0;
  int                      checked   = 0;
  logic [2:0]              ofs [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

  always #2 sys_clk = ~sys_clk;

  host_model host (.sys_clk(sys_clk), .bus(bus), .rdata(rdata));
  uart_page_regs DUT (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
                      .status(status), .cfg(cfg), .strb(strb), .page(page));

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_page(input uart_page_pkg::page_t exp);
    checked++;
    if (page !== exp) begin
      err_total++;
      $display("[ERR] page expected %b seen %b", exp, page);
    end
  endtask

  task automatic chk_cfg(input string what, input uart_page_pkg::cfg_t exp);
    checked++;
    if (cfg !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, cfg);
    end
  endtask

  function automatic logic [7:0] pulses();
    return {4'h0, strb.tx_load, strb.fifo_load, strb.mask_load, strb.rx_pop};
  endfunction

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    host.rd_byte(a, v);
    chk_byte(what, exp, v);
  endtask

  task automatic rw(input logic [2:0] a, input logic [7:0] d);
    host.wr_byte(a, d);
    rd_chk(a, d, "read back");
  endtask

  // Pulse must stand in the cycle after the write and be gone one cycle later
  task automatic wr_pulse(input logic [2:0] a, input logic [7:0] d, input logic [7:0] exp);
    host.wr_byte(a, d);
    chk_byte("strobes", exp, pulses());
    chk_byte("strobe data", d, strb.data);
    @(negedge sys_clk);
    chk_byte("strobes later", 8'h00, pulses());
  endtask

  task automatic refused(input logic [2:0] a);
    uart_page_pkg::cfg_t snap;
    snap = cfg;
    host.wr_byte(a, 8'hff);
    chk_cfg("cfg after refused write", snap);
    chk_byte("strobes", 8'h00, pulses());
  endtask

  task automatic t_reset();
    chk_cfg("cfg at reset", '0);
    chk_page(uart_page_pkg::PAGE0);
    chk_byte("rdata at reset", 8'h00, rdata);
    chk_byte("strobes at reset", 8'h00, pulses());
  endtask

  task automatic t_page0();
    rw(3'h1, 8'ha1);
    chk_byte("int_enable", 8'ha1, cfg.int_enable);
    rw(3'h7, 8'h5a);
    chk_byte("scratch_pad", 8'h5a, cfg.scratch_pad);
    wr_pulse(3'h0, 8'h3c, 8'h08);
    rd_chk(3'h0, 8'h11, "rx_buffer");
    chk_byte("rx_pop", 8'h01, pulses());
    @(negedge sys_clk);
    chk_byte("rx_pop later", 8'h00, pulses());
    wr_pulse(3'h2, 8'hc1, 8'h04);
    rd_chk(3'h2, 8'h22, "int_status");
    rd_chk(3'h5, 8'h33, "line_status");
    rd_chk(3'h6, 8'h44, "modem_status");
    refused(3'h5);
    refused(3'h6);
  endtask

  task automatic t_page1();
    rw(3'h3, 8'h83);
    chk_page(uart_page_pkg::PAGE1);
    rw(3'h0, 8'h0c);
    rw(3'h1, 8'h01);
    chk_byte("divisor_low", 8'h0c, cfg.divisor_low);
    chk_byte("divisor_high", 8'h01, cfg.divisor_high);
    chk_byte("int_enable kept", 8'ha1, cfg.int_enable);
    wr_pulse(3'h2, 8'h07, 8'h04);
    rd_chk(3'h2, 8'h22, "int_status");
    rd_chk(3'h5, 8'h33, "line_status");
    rd_chk(3'h6, 8'h44, "modem_status");
    refused(3'h5);
    rw(3'h7, 8'ha5);
    rw(3'h4, 8'h0f);
    host.wr_byte(3'h3, 8'h00);
    chk_page(uart_page_pkg::PAGE0);
  endtask

  task automatic t_page2();
    host.wr_byte(3'h4, 8'h40);
    chk_page(uart_page_pkg::PAGE2);
    wr_pulse(3'h1, 8'h96, 8'h02);
    chk_byte("int_enable kept", 8'ha1, cfg.int_enable);
    rd_chk(3'h1, uart_page_pkg::UNMAPPED_READ, "mask read");
    rd_chk(3'h0, uart_page_pkg::UNMAPPED_READ, "empty slot");
    refused(3'h0);
    rd_chk(3'h2, 8'h55, "global_int_status");
    refused(3'h2);
    rd_chk(3'h5, 8'h66, "tx_fifo_count");
    rd_chk(3'h6, 8'h77, "rx_fifo_count");
    refused(3'h5);
    rd_chk(3'h7, 8'h88, "flow_status");
    refused(3'h7);
    rd_chk(3'h3, 8'h00, "line_control");
    rd_chk(3'h4, 8'h40, "modem_control");
    host.wr_byte(3'h4, 8'h00);
    chk_page(uart_page_pkg::PAGE0);
  endtask

  task automatic t_page34();
    host.enter_page(1'b0);
    chk_page(uart_page_pkg::PAGE3);
    rd_chk(3'h0, 8'h00, "page_select");
    rd_chk(3'h3, 8'hbf, "line_control");
    foreach (ofs[i]) rw(ofs[i], 8'h30 + 8'(ofs[i]));
    chk_byte("auto_toggle_control", 8'h31, cfg.auto_toggle_control);
    chk_byte("enhanced_feature", 8'h32, cfg.enhanced_feature);
    chk_byte("resume_char_1", 8'h34, cfg.resume_char_1);
    chk_byte("resume_char_2", 8'h35, cfg.resume_char_2);
    chk_byte("pause_char_1", 8'h36, cfg.pause_char_1);
    chk_byte("pause_char_2", 8'h37, cfg.pause_char_2);
    host.enter_page(1'b1);
    chk_page(uart_page_pkg::PAGE4);
    foreach (ofs[i]) rw(ofs[i], 8'h40 + 8'(ofs[i]));
    chk_byte("additional_feature", 8'h41, cfg.additional_feature);
    chk_byte("pause_resend_count", 8'h42, cfg.pause_resend_count);
    chk_byte("tx_trigger_level", 8'h44, cfg.tx_trigger_level);
    chk_byte("rx_trigger_level", 8'h45, cfg.rx_trigger_level);
    chk_byte("flow_upper_threshold", 8'h46, cfg.flow_upper_threshold);
    chk_byte("flow_lower_threshold", 8'h47, cfg.flow_lower_threshold);
    chk_byte("pause_char_2 kept", 8'h37, cfg.pause_char_2);
    chk_byte("modem_control kept", 8'h00, cfg.modem_control);
    host.wr_byte(3'h3, 8'h03);
    chk_page(uart_page_pkg::PAGE0);
    rd_chk(3'h1, 8'ha1, "int_enable");
  endtask

  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Tests need well under a thousand cycles; this margin still catches a hang
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end

  initial begin
    status = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_page0();
    t_page1();
    t_page2();
    t_page34();
    // Mid-run reset must clear every stored byte and return to page 0
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    wrap_up();
  end
endmodule

`default_nettype wire
